// File: rtl/lss_pkg.sv
// constants for the linear array scan sequencer
// assumes one 20 MHz core clock and an asynchronous active-high reset
package lss_pkg;
    // ==========================================================
    // section geometry and data widths
    localparam int PIXEL_COUNT = 448;
    localparam int IDX_W = 9;
    localparam int DATA_W = 12;
    localparam logic [IDX_W-1:0] FIRST_PIXEL = 9'h000;
    localparam logic [IDX_W-1:0] LAST_PIXEL = 9'(PIXEL_COUNT - 1);
    localparam logic [IDX_W-1:0] PIXEL_STEP = 9'h001;
    // ==========================================================
    // sequencer states, two core cycles per pixel unless the output buffer is full
    typedef enum logic [1:0] {
        LSS_IDLE = 2'b00,
        LSS_HOLD = 2'b01,
        LSS_PRESENT = 2'b10
    } lss_state_t;
    // ==========================================================
    // output buffer
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_ONE = 2'h1;
endpackage : lss_pkg

// File: rtl/lss_scan_sequencer.sv
// readout sequencer for one section of a linear photodiode array, with a
// two-entry output buffer in the pixel data path
// assumes start_pulse and pixel_level are synchronous to core_clk; the
// analog array answers pixel_select with the held level on pixel_level
// Summary of operation
// - start selects pixel one, holds its sample and resets its integrator in the same period
// - next period releases integrator reset and returns sampler to tracking
// - every second period after that advances one pixel while the buffer has room, same sequence, in order
// - after the last pixel the output drive turns off at next edge
// - integration time is the span between two readouts of a pixel
// - each pixel value stays valid until the receiver takes it

// ==========================================================
// two-entry buffer
module lss_buf2 (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [lss_pkg::DATA_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [lss_pkg::DATA_W-1:0] out_data
);
    logic [lss_pkg::DATA_W-1:0] mem_q [lss_pkg::BUF_DEPTH];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // handshakes from the fill count
    assign in_ready = (cnt_q != lss_pkg::BUF_FULL);
    assign out_valid = (cnt_q != lss_pkg::BUF_EMPTY);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // storage and pointers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
        end
    end

    // fill count
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= lss_pkg::BUF_EMPTY;
        end else if (push && !pop) begin
            cnt_q <= cnt_q + lss_pkg::BUF_ONE;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - lss_pkg::BUF_ONE;
        end
    end

    default clocking buf_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // a word offered and not taken stays put
    word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffer output changed while stalled");
    // a push without a pop adds exactly one word and never passes two
    fill_bound_a: assert property (push && !pop |=>
        out_valid && (cnt_q == $past(cnt_q) + lss_pkg::BUF_ONE) && (cnt_q <= lss_pkg::BUF_FULL))
        else $error("buffer count wrong after push");
endmodule // lss_buf2

// ==========================================================
// scan sequencer top
module lss_scan_sequencer (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic start_pulse,
    input wire logic [lss_pkg::DATA_W-1:0] pixel_level,
    output logic [lss_pkg::IDX_W-1:0] pixel_select,
    output logic integrator_reset_switch,
    output logic sample_hold_switch,
    output logic out_drive_en,
    output logic end_of_scan_out_first,
    output logic out_valid,
    input wire logic out_ready,
    output logic [lss_pkg::DATA_W-1:0] out_data
);
    lss_pkg::lss_state_t state_q;
    logic [lss_pkg::IDX_W-1:0] pix_q;
    logic [lss_pkg::DATA_W-1:0] held_q;
    logic drive_q;
    logic eos_q;
    logic buf_in_ready;
    logic push;
    logic last_push;

    // a word is pushed in the present phase once the buffer has room
    assign push = (state_q == lss_pkg::LSS_PRESENT) && buf_in_ready;
    assign last_push = push && (pix_q == lss_pkg::LAST_PIXEL) && !start_pulse;

    // switch controls decoded from the phase
    assign sample_hold_switch = (state_q == lss_pkg::LSS_HOLD);
    assign integrator_reset_switch = (state_q == lss_pkg::LSS_HOLD);
    assign pixel_select = pix_q;
    assign out_drive_en = drive_q;
    assign end_of_scan_out_first = eos_q;

    // phase sequencing; a start always restarts at the first pixel
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= lss_pkg::LSS_IDLE;
        end else if (start_pulse) begin
            state_q <= lss_pkg::LSS_HOLD;
        end else begin
            case (state_q)
                lss_pkg::LSS_HOLD: begin
                    state_q <= lss_pkg::LSS_PRESENT;
                end
                lss_pkg::LSS_PRESENT: begin
                    if (last_push) begin
                        state_q <= lss_pkg::LSS_IDLE;
                    end else if (push) begin
                        state_q <= lss_pkg::LSS_HOLD;
                    end
                end
                default: begin
                    state_q <= lss_pkg::LSS_IDLE;
                end
            endcase
        end
    end

    // pixel counter, cleared by start
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pix_q <= lss_pkg::FIRST_PIXEL;
        end else if (start_pulse) begin
            pix_q <= lss_pkg::FIRST_PIXEL;
        end else if (push && !last_push) begin
            pix_q <= pix_q + lss_pkg::PIXEL_STEP;
        end
    end

    // capture the held level while the sampler holds
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            held_q <= '0;
        end else if (state_q == lss_pkg::LSS_HOLD) begin
            held_q <= pixel_level;
        end
    end

    // output drive and end-of-scan pulse
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            drive_q <= 1'b0;
            eos_q <= 1'b0;
        end else begin
            eos_q <= last_push;
            if (start_pulse) begin
                drive_q <= 1'b1;
            end else if (last_push) begin
                drive_q <= 1'b0;
            end
        end
    end

    lss_buf2 u_buf (
        .core_clk(core_clk),
        .reset(reset),
        .in_valid(state_q == lss_pkg::LSS_PRESENT),
        .in_ready(buf_in_ready),
        .in_data(held_q),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_data)
    );

    default clocking seq_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence hold_phase_s;
        state_q == lss_pkg::LSS_HOLD && integrator_reset_switch && sample_hold_switch;
    endsequence

    sequence release_phase_s;
        !integrator_reset_switch && !sample_hold_switch && state_q == lss_pkg::LSS_PRESENT;
    endsequence

    // start gives pixel one held and reset, then released
    start_first_pixel_a: assert property (start_pulse ##1 !start_pulse |->
        (hold_phase_s and pix_q == lss_pkg::FIRST_PIXEL) ##1 release_phase_s)
        else $error("start did not hold and reset the first pixel");
    // release follows the hold phase by one cycle
    release_after_hold_a: assert property (state_q == lss_pkg::LSS_HOLD && !start_pulse |=> release_phase_s)
        else $error("integrator reset not released after hold");
    // each accepted pixel except the last moves to the next one
    pixel_advance_a: assert property (push && !last_push && !start_pulse |=>
        state_q == lss_pkg::LSS_HOLD && pix_q == $past(pix_q) + lss_pkg::PIXEL_STEP)
        else $error("pixel did not advance by one");
    // drive stops and end of scan pulses right after the last pixel
    last_pixel_hiz_a: assert property (last_push |=> !out_drive_en && end_of_scan_out_first ##1 !end_of_scan_out_first)
        else $error("output still driven after last pixel");
    // receiver stall freezes the pixel
    stall_freeze_a: assert property (state_q == lss_pkg::LSS_PRESENT && !buf_in_ready && !start_pulse |=>
        state_q == lss_pkg::LSS_PRESENT && $stable(pix_q))
        else $error("sequencer moved on while buffer full");
    // counter only runs while the output is driven
    idle_counter_a: assert property (!out_drive_en |-> state_q == lss_pkg::LSS_IDLE)
        else $error("scan active with output off");
    // held level reaches the buffer input
    held_capture_a: assert property (state_q == lss_pkg::LSS_HOLD && !start_pulse |=> held_q == $past(pixel_level))
        else $error("held level not captured");
endmodule // lss_scan_sequencer

// File: sim/lss_array_model.sv
// behavioural model of the analog array that answers the sequencer
// assumes pixel_select and sample_hold_switch come from lss_scan_sequencer
module lss_array_model (
    input wire logic [8:0] pixel_select,
    input wire logic sample_hold_switch,
    output logic [11:0] pixel_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // held level is valid only while the sampler holds; otherwise the
    // inverse is shown so a capture in the wrong cycle is caught
    always_comb begin
        if (sample_hold_switch) begin
            pixel_level = 12'h0A5 ^ {3'h0, pixel_select}; // below full scale
        end else begin
            pixel_level = ~(12'h0A5 ^ {3'h0, pixel_select});
        end
    end
endmodule // lss_array_model

// File: sim/lss_scan_sequencer_test.sv
// self-checking bench for the scan sequencer
// assumes a 50 ns core clock; inputs change 1 ns after the rising edge
module lss_scan_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset = 1, start_pulse = 0, out_ready = 0, stall = 0;
    logic [11:0] pixel_level, out_data, last_data;
    logic [8:0] pixel_select;
    logic irs, shs, drv, eos, out_valid, prev_hold = 0, was_stalled = 0;
    logic [11:0] expq[$];
    int fails = 0, checks = 0, seed = 26, exp_pix = 0;
    // ==========================================================
    // clock, design and array model
    always #25 core_clk = ~core_clk; // fixed rate for the whole run
    lss_scan_sequencer dut (.core_clk(core_clk), .reset(reset), .start_pulse(start_pulse),
        .pixel_level(pixel_level), .pixel_select(pixel_select), .integrator_reset_switch(irs),
        .sample_hold_switch(shs), .out_drive_en(drv), .end_of_scan_out_first(eos),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
    lss_array_model array (.pixel_select(pixel_select), .sample_hold_switch(shs), .pixel_level(pixel_level));
    // ==========================================================
    // compare and verdict
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task results;
        $display("checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // receiver readiness, random stalls when asked
    always @(posedge core_clk) begin
        #1 out_ready = stall ? 1'($random(seed)) : 1'b1;
    end
    // start pulse for one edge, with the notes of all words of the scan
    task start_scan;
        @(posedge core_clk);
        #1 start_pulse = 1;
        exp_pix = 0;
        for (int i = 0; i < 448; i++) expq.push_back(12'h0A5 ^ 12'(i));
        @(posedge core_clk);
        #1 start_pulse = 0;
    endtask
    // one scan with bounded waits; the next start waits for end of scan
    task scan(input logic do_stall);
        stall = do_stall;
        start_scan();
        for (int i = 0; i < 5000 && !eos; i++) @(negedge core_clk);
        for (int i = 0; i < 100 && expq.size() != 0; i++) @(negedge core_clk);
        check(16'(expq.size()), 16'h0000, "words left over");
    endtask
    // ==========================================================
    // monitor on the falling edge, where outputs have settled
    always @(negedge core_clk) begin
        if (!reset) begin
            check(irs, shs, "switches differ");
            if (shs) begin
                check(pixel_select, 16'(exp_pix), "pixel order");
                check(drv, 1'b1, "output not driven");
                check(prev_hold, 1'b0, "hold longer than a period");
                exp_pix++;
            end
            if (was_stalled) check(out_data, last_data, "word changed while waiting");
            if (out_valid && out_ready) begin
                if (expq.size() == 0) check(1'b1, 1'b0, "unexpected word");
                else check(out_data, expq.pop_front(), "pixel word");
            end
            if (eos) begin
                check(16'(exp_pix), 16'd448, "scan length");
                check(drv, 1'b0, "output still driven");
            end
            prev_hold = shs;
            was_stalled = out_valid && !out_ready;
            last_data = out_data;
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        #1 reset = 0;
        @(negedge core_clk);
        check({drv, shs, out_valid, eos}, 4'h0, "reset state");
        scan(1'b0);
        scan(1'b1);
        scan(1'b0);
        stall = 0;
        start_scan();
        repeat (20) @(posedge core_clk);
        #1 reset = 1;
        @(negedge core_clk);
        check({drv, shs, out_valid, eos}, 4'h0, "state after reset");
        check(pixel_select, 16'h0000, "pixel after reset");
        expq.delete();
        prev_hold = 0;
        was_stalled = 0;
        @(posedge core_clk);
        #1 reset = 0;
        scan(1'b1);
        results();
    end
    // watchdog well beyond four scans with stalls
    initial begin
        #2_000_000;
        fails++;
        results();
    end
endmodule // lss_scan_sequencer_test
